// ### src/stc_pkg.sv
// Shared constants, register map and types of the sync trigger conditioner
package stc_pkg;

  localparam int NSLOT             = 4;
  localparam int CLK_HZ            = 250_000_000;
  localparam int US_PER_S          = 1_000_000;
  localparam int US_CYC            = CLK_HZ / US_PER_S;
  localparam logic [7:0] US_LAST   = 8'(US_CYC - 1);
  localparam int SAMPLE_HZ         = 400;
  localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int SAMPLE_CNT_W      = 20;

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [3:0] SLOT_PAGE_FIRST = 4'h1;
  localparam logic [3:0] OFS_CFG         = 4'h0;
  localparam logic [3:0] OFS_SKIP        = 4'h4;
  localparam logic [3:0] OFS_TIME        = 4'h8;

  localparam int CTRL_APPLY     = 0;
  localparam int CTRL_MODE      = 1;
  localparam int CTRL_SWREQ     = 2;
  localparam int STAT_REJECT    = 0;
  localparam int STAT_OUT       = 1;
  localparam int STAT_IN_LSB    = 2;
  localparam int STAT_SECOND    = 4;
  localparam int STAT_SPENT_LSB = 8;
  localparam int CFG_EN         = 0;
  localparam int CFG_FN_LSB     = 1;
  localparam int CFG_LN_LSB     = 4;
  localparam int CFG_POL_LSB    = 6;
  localparam int CFG_ONCE       = 8;
  localparam int HI_LSB         = 16;

  typedef enum logic [2:0] {
    FN_TRIG_MARK, FN_LATEST_DATA, FN_START_SAMPLING, FN_CLOCK_SYNC, FN_SAMPLE_IND, FN_SECOND_REF
  } stc_func_e;
  typedef enum logic [1:0] {LN_FIRST_IN, LN_SECOND_IN, LN_SW_REQ, LN_FIRST_OUT} stc_line_e;
  typedef enum logic [1:0] {POL_RISE, POL_FALL, POL_BOTH} stc_pol_e;
  typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_PULSE} stc_phase_e;

  typedef struct packed {
    logic        enable;
    stc_func_e   func;
    stc_line_e   line;
    stc_pol_e    pol;
    logic        once;
    logic [15:0] initial_skip_count;
    logic [15:0] periodic_skip_count;
    logic [15:0] width_us;
    logic [15:0] delay_us;
  } stc_slot_s;

  typedef struct packed {
    logic [15:0] init_left;
    logic [15:0] period_left;
    logic        spent;
    stc_phase_e  phase;
    logic [7:0]  pre;
    logic [15:0] us_left;
    logic        fire;
    logic        active;
  } stc_chan_s;

  typedef struct packed {
    logic        mark;
    logic        latest;
    logic        start;
    logic        clock;
  } stc_fn_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } stc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } stc_apb_rsp_s;

  typedef struct packed {
    logic [2:0]                  sync1;
    logic [2:0]                  sync2;
    logic [2:0]                  prev;
    stc_slot_s [NSLOT-1:0]       shadow;
    stc_slot_s [NSLOT-1:0]       active;
    logic                        rejected;
    logic [SAMPLE_CNT_W-1:0]     sample_cnt;
    logic                        sample_tick;
    logic                        sw_req;
    logic                        arm;
    logic                        mode_new;
    logic [31:0]                 prdata;
    logic                        out_line;
    stc_fn_s                     fn;
  } stc_top_s;

endpackage

// ### src/stc_channel.sv
// One sync function slot: skipping, single shot, delay and pulse width
`timescale 1ns/100ps
`default_nettype none
module stc_channel (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire stc_pkg::stc_slot_s cfg,
  input  wire logic              arm,
  input  wire logic              mode_new,
  input  wire logic              event_hit,
  output logic                   fire,
  output logic                   active,
  output logic                   spent
);
  import stc_pkg::*;

  stc_chan_s s;
  stc_chan_s n;
  logic      us_tick;
  logic      take;

  // Delay done: one-cycle fire, pulse window opening in the same cycle unless width is zero
  function automatic stc_chan_s launch(stc_chan_s c, stc_slot_s k);
    stc_chan_s r;
    r        = c;
    r.fire   = 1'b1;
    r.active = (k.width_us != 16'h0000);
    r.phase  = r.active ? PH_PULSE : PH_IDLE;
    r.us_left = k.width_us;
    return r;
  endfunction

  always_comb begin
    n       = s;
    n.fire  = 1'b0;
    us_tick = (s.pre == US_LAST);
    n.pre   = us_tick ? 8'h00 : 8'(s.pre + 8'h01);
    take    = event_hit && cfg.enable && !s.spent && (s.phase == PH_IDLE);
    // R13: new mode re-arms single shot
    if (mode_new) begin
      n.spent = 1'b0;
    end
    if (arm) begin
      n.init_left   = cfg.initial_skip_count;
      n.period_left = 16'h0000;
      n.spent       = 1'b0;
      n.phase       = PH_IDLE;
      n.active      = 1'b0;
    end else begin
      unique case (s.phase)
        PH_IDLE: begin
          if (take) begin
            if (s.init_left != 16'h0000) begin
              // R9: drop first edges after arming
              n.init_left = 16'(s.init_left - 16'h0001);
            end else if (s.period_left != 16'h0000) begin
              // R10: periodic discard
              n.period_left = 16'(s.period_left - 16'h0001);
            end else begin
              n.period_left = cfg.periodic_skip_count;
              // R11 R12: shot consumed only past skipping
              n.spent = cfg.once;
              n.pre   = 8'h00;
              if (cfg.delay_us == 16'h0000) begin
                n = launch(n, cfg);
              end else begin
                // R15: wait before reacting
                n.phase   = PH_DELAY;
                n.us_left = cfg.delay_us;
              end
            end
          end
        end
        PH_DELAY: begin
          if (us_tick) begin
            if (s.us_left == 16'h0001) begin
              n = launch(n, cfg);
            end else begin
              n.us_left = 16'(s.us_left - 16'h0001);
            end
          end
        end
        PH_PULSE: begin
          // R14: pulse lasts width in microseconds
          if (us_tick) begin
            if (s.us_left == 16'h0001) begin
              n.phase  = PH_IDLE;
              n.active = 1'b0;
            end else begin
              n.us_left = 16'(s.us_left - 16'h0001);
            end
          end
        end
        default: n.phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign fire   = s.fire;
  assign active = s.active;
  assign spent  = s.spent;

  // R9 R12: skipped edge neither acts nor spends
  a_initial_skip: assert property (@(posedge clk) disable iff (reset) // R9
    (!arm && take && s.init_left != 16'h0000) |=>
      (!s.fire && s.phase == PH_IDLE && s.spent == $past(s.spent) && s.init_left == $past(s.init_left) - 16'h0001))
    else $error("initial skip edge was acted on");

  // R10: periodic skip holds off
  a_periodic_skip: assert property (@(posedge clk) disable iff (reset) // R10
    (!arm && take && s.init_left == 16'h0000 && s.period_left != 16'h0000) |=> (!s.fire && s.phase == PH_IDLE))
    else $error("periodically skipped edge was acted on");

  // R11: spent slot ignores edges
  a_single_shot: assert property (@(posedge clk) disable iff (reset) // R11
    (s.spent && s.phase == PH_IDLE && !arm && !mode_new) |=> (s.phase == PH_IDLE && !s.fire))
    else $error("single shot acted twice");

  // R15: no reaction while delay runs
  a_delay_wait: assert property (@(posedge clk) disable iff (reset) // R15
    (s.phase == PH_DELAY && !arm && (s.us_left > 16'h0001 || !us_tick)) |=> (!s.fire && s.phase == PH_DELAY))
    else $error("reaction before delay elapsed");

  // R14: pulse window loaded with width
  a_pulse_width: assert property (@(posedge clk) disable iff (reset) // R14
    $rose(s.active) |-> (s.us_left == cfg.width_us && s.fire && s.pre != US_LAST))
    else $error("pulse width not loaded");

endmodule
`default_nettype wire

// ### src/stc_conditioner.sv
// Sync trigger conditioner top: APB registers, line sync, slot routing
//
// Overview of operation
// R1: Two trigger inputs, one trigger output only
// R2: Reject configs mixing line directions
// R3: Output reference pulse aligned to second pulse
// R4: Triggers are pulses, in or out
// R5: Line selector: input, software request, output
// R6: Per-line slots, each with own parameters
// R7: Software request only for latest-data output
// R8: Polarity picks rising, falling or both
// R9: Drop first n edges after arming
// R10: Then periodically drop per periodic skip count
// R11: Single shot acts once, ignores rest
// R12: Single shot counted only after skipping
// R13: New measurement mode re-arms single shot
// R14: Pulse width in microseconds per function
// R15: Delay in microseconds before reacting
// R16: Whole configuration set applied as unit
// R17: Latest-data from input line or software
// R18: Sampling indication from 400 Hz clock
// R19: Two-stage synchroniser before edge detection
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module stc_conditioner #(
  parameter int SAMPLE_PERIOD = stc_pkg::SAMPLE_PERIOD_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire stc_pkg::stc_apb_req_s apb_req,
  output stc_pkg::stc_apb_rsp_s      apb_rsp,
  input  wire logic [1:0]            trigger_input_line,
  input  wire logic                  receiver_second_pulse,
  output logic                       trigger_output_line,
  output stc_pkg::stc_fn_s           fn_pulse
);
  import stc_pkg::*;

  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_PERIOD - 1);

  stc_top_s          s;
  stc_top_s          n;
  logic [NSLOT-1:0]  ch_event;
  logic [NSLOT-1:0]  ch_fire;
  logic [NSLOT-1:0]  ch_active;
  logic [NSLOT-1:0]  ch_spent;
  logic              all_legal;
  logic              apply_wr;
  logic              any_out;
  logic [1:0]        widx;
  logic [3:0]        page;

  // R8: edge qualifier
  function automatic logic edge_hit(stc_pol_e pol, logic prev, logic cur);
    logic r;
    r = 1'b0;
    unique case (pol)
      POL_RISE: r = cur && !prev;
      POL_FALL: r = !cur && prev;
      POL_BOTH: r = cur ^ prev;
      default:  r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic is_out_fn(stc_func_e f);
    return (f == FN_SAMPLE_IND) || (f == FN_SECOND_REF);
  endfunction

  // R2 R5 R7: legal line per function
  function automatic logic slot_legal(stc_slot_s k);
    logic ok;
    ok = 1'b0;
    unique case (k.func)
      FN_SAMPLE_IND, FN_SECOND_REF: ok = (k.line == LN_FIRST_OUT);
      FN_LATEST_DATA:               ok = (k.line != LN_FIRST_OUT);
      FN_TRIG_MARK, FN_START_SAMPLING, FN_CLOCK_SYNC:
        ok = (k.line == LN_FIRST_IN) || (k.line == LN_SECOND_IN);
      default:                      ok = 1'b0;
    endcase
    return !k.enable || (ok && k.pol != 2'h3);
  endfunction

  function automatic logic addr_ok(logic [7:0] a);
    logic [3:0] pg;
    pg = a[7:4];
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
           (pg >= SLOT_PAGE_FIRST && pg <= 4'(NSLOT) &&
            (a[3:0] == OFS_CFG || a[3:0] == OFS_SKIP || a[3:0] == OFS_TIME));
  endfunction

  always_comb begin
    n        = s;
    ch_event = '0;
    any_out  = 1'b0;
    all_legal = 1'b1;
    page     = apb_req.paddr[7:4];
    widx     = 2'(page - SLOT_PAGE_FIRST);
    // R19: pins pass two flops before edge logic
    n.sync1    = {receiver_second_pulse, trigger_input_line};
    n.sync2    = s.sync1;
    n.prev     = s.sync2;
    n.arm      = 1'b0;
    n.mode_new = 1'b0;
    n.sw_req   = 1'b0;
    // R18: 400 Hz sampling clock
    n.sample_tick = (s.sample_cnt == '0);
    n.sample_cnt  = (s.sample_cnt == '0) ? SAMPLE_LAST : SAMPLE_CNT_W'(s.sample_cnt - 1'b1);

    for (int i = 0; i < NSLOT; i++) begin
      all_legal = all_legal && slot_legal(s.shadow[i]);
      // R5 R6 R17: source selection per slot
      unique case (s.active[i].line)
        LN_FIRST_IN:  ch_event[i] = edge_hit(s.active[i].pol, s.prev[0], s.sync2[0]);
        LN_SECOND_IN: ch_event[i] = edge_hit(s.active[i].pol, s.prev[1], s.sync2[1]);
        // R7: software request feeds latest-data only
        LN_SW_REQ:    ch_event[i] = s.sw_req && (s.active[i].func == FN_LATEST_DATA);
        // R3: second reference tracks receiver pulse edge
        LN_FIRST_OUT: ch_event[i] = (s.active[i].func == FN_SECOND_REF) ?
                                    edge_hit(s.active[i].pol, s.prev[2], s.sync2[2]) : s.sample_tick;
        default:      ch_event[i] = 1'b0;
      endcase
      if (ch_active[i] && is_out_fn(s.active[i].func)) begin
        any_out = 1'b1;
      end
    end

    // R4: input slots report their reaction as pulses
    n.fn = '0;
    for (int i = 0; i < NSLOT; i++) begin
      if (ch_fire[i]) begin
        unique case (s.active[i].func)
          FN_TRIG_MARK:      n.fn.mark   = 1'b1;
          FN_LATEST_DATA:    n.fn.latest = 1'b1;
          FN_START_SAMPLING: n.fn.start  = 1'b1;
          FN_CLOCK_SYNC:     n.fn.clock  = 1'b1;
          default:           n.fn.mark   = n.fn.mark;
        endcase
      end
    end
    // R1 R4: single output line driven by output slots
    n.out_line = any_out;

    // Read data captured in setup so access can finish at once
    if (apb_req.psel && !apb_req.penable) begin
      n.prdata = 32'h0000_0000;
      if (apb_req.paddr == ADDR_STATUS) begin
        n.prdata[STAT_REJECT]                  = s.rejected;
        n.prdata[STAT_OUT]                     = s.out_line;
        n.prdata[STAT_IN_LSB +: 2]             = s.sync2[1:0];
        n.prdata[STAT_SECOND]                  = s.sync2[2];
        n.prdata[STAT_SPENT_LSB +: NSLOT]      = ch_spent;
      end else if (addr_ok(apb_req.paddr) && apb_req.paddr != ADDR_CTRL) begin
        unique case (apb_req.paddr[3:0])
          OFS_CFG: begin
            n.prdata[CFG_EN]               = s.shadow[widx].enable;
            n.prdata[CFG_FN_LSB +: 3]      = s.shadow[widx].func;
            n.prdata[CFG_LN_LSB +: 2]      = s.shadow[widx].line;
            n.prdata[CFG_POL_LSB +: 2]     = s.shadow[widx].pol;
            n.prdata[CFG_ONCE]             = s.shadow[widx].once;
          end
          OFS_SKIP: n.prdata = {s.shadow[widx].periodic_skip_count, s.shadow[widx].initial_skip_count};
          OFS_TIME: n.prdata = {s.shadow[widx].delay_us, s.shadow[widx].width_us};
          default:  n.prdata = 32'h0000_0000;
        endcase
      end
    end

    apply_wr = 1'b0;
    if (apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok(apb_req.paddr)) begin
      if (apb_req.paddr == ADDR_CTRL) begin
        apply_wr   = apb_req.pwdata[CTRL_APPLY];
        n.mode_new = apb_req.pwdata[CTRL_MODE];
        n.sw_req   = apb_req.pwdata[CTRL_SWREQ];
      end else if (apb_req.paddr != ADDR_STATUS) begin
        unique case (apb_req.paddr[3:0])
          OFS_CFG: begin
            n.shadow[widx].enable = apb_req.pwdata[CFG_EN];
            n.shadow[widx].func   = stc_func_e'(apb_req.pwdata[CFG_FN_LSB +: 3]);
            n.shadow[widx].line   = stc_line_e'(apb_req.pwdata[CFG_LN_LSB +: 2]);
            n.shadow[widx].pol    = stc_pol_e'(apb_req.pwdata[CFG_POL_LSB +: 2]);
            n.shadow[widx].once   = apb_req.pwdata[CFG_ONCE];
          end
          OFS_SKIP: begin
            n.shadow[widx].initial_skip_count  = apb_req.pwdata[HI_LSB-1:0];
            n.shadow[widx].periodic_skip_count = apb_req.pwdata[31:HI_LSB];
          end
          OFS_TIME: begin
            n.shadow[widx].width_us = apb_req.pwdata[HI_LSB-1:0];
            n.shadow[widx].delay_us = apb_req.pwdata[31:HI_LSB];
          end
          default: n.shadow[widx] = s.shadow[widx];
        endcase
      end
    end

    // R16 R2: whole set goes live or none of it
    if (apply_wr) begin
      n.rejected = !all_legal;
      if (all_legal) begin
        n.active = s.shadow;
        n.arm    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // R6: independent slot per line and function
  generate
    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
      stc_channel u_chan (
        .clk       (clk),
        .reset     (reset),
        .cfg       (s.active[g]),
        .arm       (s.arm),
        .mode_new  (s.mode_new),
        .event_hit (ch_event[g]),
        .fire      (ch_fire[g]),
        .active    (ch_active[g]),
        .spent     (ch_spent[g])
      );
    end
  endgenerate

  // Zero wait states; unmapped access flagged
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok(apb_req.paddr);
  assign apb_rsp.prdata  = s.prdata;
  assign trigger_output_line = s.out_line;
  assign fn_pulse            = s.fn;

  // R2: illegal set leaves live config untouched
  a_reject_keep: assert property (@(posedge clk) disable iff (reset) // R2
    (apply_wr && !all_legal) |=> (s.rejected && !s.arm && s.active == $past(s.active)))
    else $error("illegal configuration was applied");

  // R16: legal set copied whole and armed in the same cycle
  a_unit_apply: assert property (@(posedge clk) disable iff (reset) // R16
    (apply_wr && all_legal) |=> (s.active == $past(s.shadow) && s.arm && !s.rejected))
    else $error("configuration not applied as one unit");

  // R19: rising event seen three edges after pin rose
  a_sync_delay: assert property (@(posedge clk) disable iff (reset) // R19
    (ch_event[0] && s.active[0].line == LN_FIRST_IN && s.active[0].pol == POL_RISE) |->
      ($past(trigger_input_line[0], 2) && !$past(trigger_input_line[0], 3)))
    else $error("input edge not from synchronised pin");

  // R18: sampling tick paired with counter reload
  a_sample_tick: assert property (@(posedge clk) disable iff (reset) // R18
    s.sample_tick |-> (s.sample_cnt == SAMPLE_LAST && $past(s.sample_cnt) == '0 && !$past(s.sample_tick)))
    else $error("sampling tick out of step");

  // R7: software request never marks or starts
  a_sw_route: assert property (@(posedge clk) disable iff (reset) // R7
    (s.sw_req && ch_event[0] && s.active[0].line == LN_SW_REQ) |-> (s.active[0].func == FN_LATEST_DATA))
    else $error("software request drove wrong function");

  // R3: output line follows output slot window
  a_out_follow: assert property (@(posedge clk) disable iff (reset) // R3
    any_out |=> trigger_output_line ##1 (trigger_output_line == $past(any_out)))
    else $error("output line not following slot pulse");

  // Status read returns live reject flag
  a_status_read: assert property (@(posedge clk) disable iff (reset)
    (apb_req.psel && !apb_req.penable && apb_req.paddr == ADDR_STATUS) |=>
      (apb_rsp.prdata[STAT_REJECT] == $past(s.rejected)))
    else $error("status read mismatch");

  // R13: mode write gives next-cycle pulse
  a_mode_pulse: assert property (@(posedge clk) disable iff (reset) // R13
    (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == ADDR_CTRL) |=>
      (s.mode_new == $past(apb_req.pwdata[CTRL_MODE])))
    else $error("mode pulse missing");

  // R17: software request write gives pulse
  a_swreq_pulse: assert property (@(posedge clk) disable iff (reset) // R17
    (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == ADDR_CTRL) |=>
      (s.sw_req == $past(apb_req.pwdata[CTRL_SWREQ])))
    else $error("software request pulse missing");

  // R16: apply arms only a legal set
  a_apply_arm: assert property (@(posedge clk) disable iff (reset) // R16
    (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == ADDR_CTRL) |=>
      (s.arm == ($past(apb_req.pwdata[CTRL_APPLY]) && $past(all_legal))))
    else $error("arm pulse out of step");

  // R16: arm lasts one cycle
  a_arm_single: assert property (@(posedge clk) disable iff (reset) // R16
    s.arm |=> !s.arm)
    else $error("arm pulse too long");

  // R13: mode pulse lasts one cycle
  a_mode_single: assert property (@(posedge clk) disable iff (reset) // R13
    s.mode_new |=> !s.mode_new)
    else $error("mode pulse too long");

  // R2: reject flag tracks last apply
  a_reject_flag: assert property (@(posedge clk) disable iff (reset) // R2
    apply_wr |=> (s.rejected == !$past(all_legal)))
    else $error("reject flag wrong after apply");

  // R2: reject flag moves only on apply
  a_reject_hold: assert property (@(posedge clk) disable iff (reset) // R2
    !apply_wr |=> $stable(s.rejected))
    else $error("reject flag changed without apply");

  // R16: status writes leave shadow alone
  a_status_nowr: assert property (@(posedge clk) disable iff (reset) // R16
    (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == ADDR_STATUS) |=>
      (s.shadow == $past(s.shadow)))
    else $error("status write changed shadow");

  // R16: unmapped writes change nothing
  a_bad_addr_nowr: assert property (@(posedge clk) disable iff (reset) // R16
    (apb_req.psel && apb_req.penable && apb_req.pwrite && !addr_ok(apb_req.paddr)) |=>
      (s.shadow == $past(s.shadow) && !s.arm))
    else $error("unmapped write took effect");

  // Read data stands until next setup
  a_prdata_hold: assert property (@(posedge clk) disable iff (reset)
    !(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata))
    else $error("read data changed outside setup");

  // Control register reads back zero
  a_ctrl_read_zero: assert property (@(posedge clk) disable iff (reset)
    (apb_req.psel && !apb_req.penable && apb_req.paddr == ADDR_CTRL) |=> (apb_rsp.prdata == 32'h0000_0000))
    else $error("control read not zero");

  // R3: second reference from synced pulse edge
  a_second_sync: assert property (@(posedge clk) disable iff (reset) // R3
    (ch_event[0] && s.active[0].line == LN_FIRST_OUT && s.active[0].func == FN_SECOND_REF &&
     s.active[0].pol == POL_RISE) |-> ($past(receiver_second_pulse, 2) && !$past(receiver_second_pulse, 3)))
    else $error("second reference edge not from synced pulse");

  // R19: second flop fed only by first
  a_sync_chain: assert property (@(posedge clk) disable iff (reset) // R19
    (s.sync2 == $past(s.sync1)))
    else $error("synchroniser chain broken");

  // R18: ticks never back to back
  a_tick_gap: assert property (@(posedge clk) disable iff (reset) // R18
    s.sample_tick |=> !s.sample_tick)
    else $error("sampling ticks back to back");

  // R4: reaction pulse only after slot fire
  a_fn_from_fire: assert property (@(posedge clk) disable iff (reset) // R4
    (|s.fn) |-> $past(|ch_fire))
    else $error("reaction pulse without fire");

endmodule
`default_nettype wire

// ### testbench/stc_trig_src.sv
// Far-side trigger source model: pulse waves on both inputs and second pulse
`timescale 1ns/100ps
`default_nettype none
module stc_trig_src (
  input  wire logic       clk,
  output logic      [1:0] trig,
  output logic            pps
);
  initial begin
    trig = 2'h0;
    pps = 1'b0;
  end
  task automatic pulse(input int ln, input int hi, input int lo);
    @(posedge clk);
    if (ln == 2) pps <= 1'b1;
    else trig[ln] <= 1'b1;
    repeat (hi) @(posedge clk);
    if (ln == 2) pps <= 1'b0;
    else trig[ln] <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/stc_conditioner_tb.sv
// Self-checking bench of the sync trigger conditioner
`timescale 1ns/100ps
`default_nettype none
module stc_conditioner_tb;
  import stc_pkg::*;
  // Short sample period keeps the run brief
  localparam int SP = 600;
  logic         clk;
  logic         reset;
  stc_apb_req_s req;
  stc_apb_rsp_s rsp;
  logic [1:0]   trig;
  logic         pps;
  logic         tout;
  stc_fn_s      fn;
  int           error_cnt;
  int           checks;
  int           cnt [4];
  logic [31:0]  q;
  logic         e;

  stc_conditioner #(.SAMPLE_PERIOD(SP)) u_dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .trigger_input_line(trig), .receiver_second_pulse(pps), .trigger_output_line(tout), .fn_pulse(fn));
  stc_trig_src u_src (.clk(clk), .trig(trig), .pps(pps));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Reaction pulses counted per function bit
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) if (fn[i] === 1'b1) cnt[i]++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo;
    error_cnt++;
    report_and_stop;
  endtask

  // Entered just after an edge; leaves one idle cycle so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 20) tmo;
    @(posedge clk);
  endtask

  task automatic slot(input int f, input int ln, input int pol, input int once, input logic [31:0] skip,
                      input logic [31:0] tm);
    apb(1'b1, {SLOT_PAGE_FIRST, OFS_CFG},
        32'(1 + (f << CFG_FN_LSB) + (ln << CFG_LN_LSB) + (pol << CFG_POL_LSB) + (once << CFG_ONCE)));
    apb(1'b1, {SLOT_PAGE_FIRST, OFS_SKIP}, skip);
    apb(1'b1, {SLOT_PAGE_FIRST, OFS_TIME}, tm);
    apb(1'b1, ADDR_CTRL, 32'h1);
  endtask

  // Cycles from second pulse start to output rise, then output high time
  task automatic lat(output int l, output int w);
    l = 0;
    w = 0;
    fork
      u_src.pulse(2, 20, 20);
    join_none
    while (tout !== 1'b1 && l < 3000) begin
      @(posedge clk);
      l++;
    end
    while (tout === 1'b1 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (l >= 3000 || w >= 3000) tmo;
  endtask

  task automatic t_regs;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status at reset", q, 32'h0);
    apb(1'b1, {SLOT_PAGE_FIRST, OFS_CFG}, 32'h1c7);
    apb(1'b0, {SLOT_PAGE_FIRST, OFS_CFG}, 32'h0);
    chk("cfg readback", q, 32'h1c7);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped error", 32'(e), 32'h1);
  endtask

  task automatic t_skip;
    int f;
    int c0;
    for (int k = 0; k < 3; k++) begin
      f = (k == 0) ? 0 : k + 1;
      c0 = cnt[3 - f];
      slot(f, 0, 0, 0, {16'h1, 16'h2}, 32'h0);
      repeat (6) u_src.pulse(0, 10, 10);
      chk("skip count", 32'(cnt[3 - f] - c0), 32'h2);
    end
  endtask

  task automatic t_once;
    int c0;
    c0 = cnt[3];
    slot(0, 1, 2, 1, 32'h1, 32'h0);
    repeat (3) u_src.pulse(1, 10, 10);
    chk("once count", 32'(cnt[3] - c0), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("shot spent", 32'(q[STAT_SPENT_LSB]), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("shot rearmed", 32'(q[STAT_SPENT_LSB]), 32'h0);
    u_src.pulse(1, 10, 10);
    chk("once again", 32'(cnt[3] - c0), 32'h2);
  endtask

  task automatic t_sw;
    int c0;
    c0 = cnt[2];
    slot(1, 2, 0, 0, 32'h0, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h4);
    repeat (8) @(posedge clk);
    chk("sw request", 32'(cnt[2] - c0), 32'h1);
    slot(0, 3, 0, 0, 32'h0, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("input on output", 32'(q[STAT_REJECT]), 32'h1);
    slot(1, 0, 0, 0, 32'h0, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("legal apply", 32'(q[STAT_REJECT]), 32'h0);
    slot(0, 2, 0, 0, 32'h0, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("sw other func", 32'(q[STAT_REJECT]), 32'h1);
  endtask

  task automatic t_out;
    int a;
    int b;
    int w;
    slot(5, 3, 0, 0, 32'h0, {16'd1, 16'd2});
    lat(a, w);
    chk("out width", 32'(w), 32'd500);
    // Falling edge comes 20 cycles later, delay grows by 2 us
    slot(5, 3, 1, 0, 32'h0, {16'd3, 16'd2});
    lat(b, w);
    chk("out delay", 32'(b - a), 32'd520);
    slot(4, 3, 0, 0, 32'h0, 32'h1);
    lat(a, w);
    lat(b, a);
    chk("sample period", 32'(w + b), 32'(SP));
    chk("sample width", 32'(a), 32'd250);
  endtask

  initial begin
    req = '0;
    reset = 1'b1;
    error_cnt = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs;
    t_skip;
    t_once;
    t_sw;
    t_out;
    report_and_stop;
  end
endmodule
`default_nettype wire
